// File: design/cdpc_pkg.sv
// Package for the CDROM, volume and peripheral pin configuration block.
// Assumes one 20 MHz clock domain and no register bus: all bits are ports.
package cdpc_pkg;

   // ----------------------------------------------------------------
   // Address port choices
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_PORT_STD  = 12'h279; // Standard port
   localparam logic [11:0] ADDR_PORT_ALT1 = 12'h308; // Serial clock strap high
   localparam logic [11:0] ADDR_PORT_ALT2 = 12'h388; // Serial clock strap low

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int          VOL_W       = 6;           // Volume field width
   localparam int          CD_ADDR_W   = 12;          // Decoded address width
   localparam logic [5:0]  VOL_RESET   = 6'h00;       // Volume after reset
   localparam logic [5:0]  VOL_MAX     = 6'h3f;       // Volume ceiling
   localparam logic [5:0]  VOL_MIN     = 6'h00;       // Volume floor
   localparam int          SA_HI_LSB   = 12;          // Upper address LSB

   // Role of the three-way pin
   typedef enum logic [1:0] {
      MUX_GEN_OUT,
      MUX_ALT_CS,
      MUX_VOL_DOWN
   } cdpc_mux_role_t;

   // Volume button mode
   typedef enum logic {
      MUTE_ABSENT,
      MUTE_MOMENTARY
   } cdpc_mute_mode_t;

   // Straps sampled when the ISA reset drive falls
   typedef struct packed {
      logic cd_port_en;   // CDROM port enabled
      logic alt_cs_en;    // Alternate select enabled
      logic addr_sel_std; // Standard address port
      logic scl_high;     // Serial clock strap level
   } cdpc_straps_t;

   // Left and right master volume
   typedef struct packed {
      logic [5:0] left;
      logic [5:0] right;
      logic       mute;
   } cdpc_volume_t;

endpackage

// File: design/cdpc_pin_config.sv
// Pin configuration logic for the CDROM, volume buttons and peripheral pins.
// Assumes all pin inputs are synchronous to ref_clk; straps held during reset.
`timescale 1ns/1ps

// Notes on behaviour
// - Four CDROM pins default to upper address
// - Sample clock strap as reset drive falls
// - Chip select low on base match
// - Mux pin follows general output one
// - Data-out strap low selects alternate select
// - Volume enable makes mux pin volume-down
// - Volume-up low raises both volumes
// - Volume-down low lowers both volumes
// - Mute only with volume pins, format chosen
// - Interrupt forwarded, polarity programmable, high default
// - DMA request forwarded to chosen line
// - ISA DMA acknowledge passed to drive
// - Master clock out unless disable set
// - Address port from two straps
// - Port enable lets three input-only pins be sampled
// - Clock strap low enables CDROM interface
module cdpc_pin_config #(
   parameter int ADDR_W = 12,     // Decoded ISA address width
   parameter int IRQ_N  = 8,      // Selectable ISA interrupt lines
   parameter int DRQ_N  = 4       // Selectable ISA DMA lines
) (
   // Clock, reset and enable
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 clk_en,
   // ISA side
   input  wire logic                 reset_drive,
   input  wire logic [ADDR_W-1:0]    isa_addr,
   input  wire logic                 isa_addr_valid,
   input  wire logic [3:0]           multi_pins_in,
   output logic [3:0]                isa_upper_addr,
   output logic [IRQ_N-1:0]          isa_irq,
   output logic [DRQ_N-1:0]          isa_drq,
   input  wire logic [DRQ_N-1:0]     isa_dack_n,
   // Configuration
   input  wire logic [ADDR_W-1:0]    cd_base,
   input  wire logic [ADDR_W-1:0]    alt_cd_base,
   input  wire logic [$clog2(IRQ_N)-1:0] irq_sel,
   input  wire logic [$clog2(DRQ_N)-1:0] drq_sel,
   input  wire logic                 cd_irq_polarity,
   input  wire logic                 general_output_one,
   input  wire logic                 volume_pins_enable,
   input  wire logic                 volume_format_select,
   input  wire logic                 master_clock_disable,
   input  wire logic                 video_audio_port_enable,
   // Straps
   input  wire logic                 mclk_strap_in,
   input  wire logic                 sdout_strap_in,
   input  wire logic                 port_address_strap,
   input  wire logic                 scl_strap_in,
   // CDROM drive
   output logic                      cd_chip_select_n,
   input  wire logic                 cd_interrupt_in,
   input  wire logic                 cd_dma_request_in,
   output logic                      cd_dma_ack_out_n,
   // Three-way pin
   output logic                      mux_pin_out,
   output logic                      mux_pin_oe,
   input  wire logic                 mux_pin_in,
   // Volume buttons
   input  wire logic                 vol_up_n,
   input  wire logic                 vol_mute_n,
   output cdpc_pkg::cdpc_volume_t    master_volume,
   // Synthesizer clock
   input  wire logic                 xtal_clk_gate_in,
   output logic                      synth_mclk,
   output logic                      synth_mclk_oe,
   // Video-audio port
   input  wire logic [2:0]           va_pins_in,
   output logic                      va_pins_oe,
   output logic                      video_audio_serial_in,
   output logic                      video_audio_lr_clock,
   output logic                      video_audio_bit_clock,
   // Status
   output cdpc_pkg::cdpc_straps_t    straps,
   output logic [11:0]               config_addr_port,
   output cdpc_pkg::cdpc_mux_role_t  mux_role
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cdpc_pkg::cdpc_straps_t straps_ff, nxt_straps;  // Latched straps
   logic                   resdrv_ff, nxt_resdrv;  // Last reset drive
   logic [1:0]             up_sync_ff, nxt_up_sync;     // Up synchroniser
   logic [1:0]             dn_sync_ff, nxt_dn_sync;     // Down synchroniser
   logic [1:0]             mu_sync_ff, nxt_mu_sync;     // Mute synchroniser
   logic                   up_last_ff, nxt_up_last;     // Up edge history
   logic                   dn_last_ff, nxt_dn_last;     // Down edge history
   logic                   mu_last_ff, nxt_mu_last;     // Mute edge history
   cdpc_pkg::cdpc_volume_t vol_ff, nxt_vol;             // Master volume
   logic                   cs_ff, nxt_cs;               // Chip select
   logic                   acs_ff, nxt_acs;             // Alternate select
   logic                   mux_out_ff, nxt_mux_out;     // Mux pin level
   logic                   irq_lvl;                     // Interrupt level
   logic [2:0]             va_ff, nxt_va;               // Port samples
   cdpc_pkg::cdpc_mux_role_t role;                      // Mux pin role

   // Address match against a programmed base
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b,
                                     input logic              v);
      addr_hit = v && (a == b);
   endfunction

   // Saturating one-step volume change
   function automatic logic [5:0] vol_step(input logic [5:0] v,
                                           input logic       up,
                                           input logic       dn);
      vol_step = v;
      if (up && !dn && v != cdpc_pkg::VOL_MAX) begin
         vol_step = v + 6'h01;
      end else if (dn && !up && v != cdpc_pkg::VOL_MIN) begin
         vol_step = v - 6'h01;
      end
   endfunction

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // Straps are caught on the falling edge of the reset drive
   always_comb begin
      nxt_resdrv = reset_drive;
      nxt_straps = straps_ff;
      if (resdrv_ff && !reset_drive) begin
         nxt_straps.cd_port_en   = !mclk_strap_in;
         nxt_straps.alt_cs_en    = !sdout_strap_in;
         nxt_straps.addr_sel_std = port_address_strap;
         nxt_straps.scl_high     = scl_strap_in;
      end
   end

   // Register strap state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         resdrv_ff <= 1'b1;
         straps_ff <= '{cd_port_en: 1'b0, alt_cs_en: 1'b0,
                        addr_sel_std: 1'b1, scl_high: 1'b1};
      end else if (clk_en) begin
         resdrv_ff <= nxt_resdrv;
         straps_ff <= nxt_straps;
      end
   end

   // ----------------------------------------------------------------
   // Pin roles and chip selects
   // ----------------------------------------------------------------
   // Volume enable beats alternate select beats general output
   always_comb begin
      if (volume_pins_enable) begin
         role = cdpc_pkg::MUX_VOL_DOWN;
      end else if (straps_ff.alt_cs_en) begin
         role = cdpc_pkg::MUX_ALT_CS;
      end else begin
         role = cdpc_pkg::MUX_GEN_OUT;
      end
   end

   // Next chip select and mux pin levels
   always_comb begin
      nxt_cs  = !(straps_ff.cd_port_en &&
                  addr_hit(isa_addr, cd_base, isa_addr_valid));
      nxt_acs = !addr_hit(isa_addr, alt_cd_base, isa_addr_valid);
      case (role)
         cdpc_pkg::MUX_GEN_OUT:  nxt_mux_out = general_output_one;
         cdpc_pkg::MUX_ALT_CS:   nxt_mux_out = nxt_acs;
         cdpc_pkg::MUX_VOL_DOWN: nxt_mux_out = 1'b1;
         default:                nxt_mux_out = 1'b1;
      endcase
   end

   // Register chip selects
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cs_ff      <= 1'b1;
         acs_ff     <= 1'b1;
         mux_out_ff <= 1'b0;
      end else if (clk_en) begin
         cs_ff      <= nxt_cs;
         acs_ff     <= nxt_acs;
         mux_out_ff <= nxt_mux_out;
      end
   end

   // ----------------------------------------------------------------
   // Volume buttons
   // ----------------------------------------------------------------
   // Synchronise buttons and step once per falling edge
   always_comb begin
      nxt_up_sync = {up_sync_ff[0], vol_up_n};
      nxt_dn_sync = {dn_sync_ff[0], mux_pin_in};
      nxt_mu_sync = {mu_sync_ff[0], vol_mute_n};
      nxt_up_last = up_sync_ff[1];
      nxt_dn_last = dn_sync_ff[1];
      nxt_mu_last = mu_sync_ff[1];
      nxt_vol     = vol_ff;
      if (volume_pins_enable) begin
         nxt_vol.left = vol_step(vol_ff.left,
                                 up_last_ff && !up_sync_ff[1],
                                 dn_last_ff && !dn_sync_ff[1]);
         nxt_vol.right = vol_step(vol_ff.right,
                                  up_last_ff && !up_sync_ff[1],
                                  dn_last_ff && !dn_sync_ff[1]);
         // Momentary mute toggles; absent format ignores it
         if (volume_format_select == cdpc_pkg::MUTE_MOMENTARY &&
             mu_last_ff && !mu_sync_ff[1]) begin
            nxt_vol.mute = !vol_ff.mute;
         end
      end
   end

   // Register button state and volume
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_sync_ff <= 2'h3;
         dn_sync_ff <= 2'h3;
         mu_sync_ff <= 2'h3;
         up_last_ff <= 1'b1;
         dn_last_ff <= 1'b1;
         mu_last_ff <= 1'b1;
         vol_ff     <= '{left: cdpc_pkg::VOL_RESET,
                         right: cdpc_pkg::VOL_RESET, mute: 1'b0};
      end else if (clk_en) begin
         up_sync_ff <= nxt_up_sync;
         dn_sync_ff <= nxt_dn_sync;
         mu_sync_ff <= nxt_mu_sync;
         up_last_ff <= nxt_up_last;
         dn_last_ff <= nxt_dn_last;
         mu_last_ff <= nxt_mu_last;
         vol_ff     <= nxt_vol;
      end
   end

   // ----------------------------------------------------------------
   // Video-audio port sampling
   // ----------------------------------------------------------------
   // Pins are sampled only while the port is enabled
   always_comb begin
      nxt_va = video_audio_port_enable ? va_pins_in : 3'h0;
   end

   // Register port samples
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         va_ff <= 3'h0;
      end else if (clk_en) begin
         va_ff <= nxt_va;
      end
   end

   // ----------------------------------------------------------------
   // Pass-through and outputs
   // ----------------------------------------------------------------
   // Polarity bit set inverts the input; clear keeps it active high
   assign irq_lvl = cd_interrupt_in ^ cd_irq_polarity;
   // Route interrupt and DMA request to the chosen ISA lines
   always_comb begin
      isa_irq = '0;
      isa_drq = '0;
      if (straps_ff.cd_port_en) begin
         isa_irq[irq_sel] = irq_lvl;
         isa_drq[drq_sel] = cd_dma_request_in;
      end
   end
   // Acknowledge of the selected channel goes to the drive
   assign cd_dma_ack_out_n = straps_ff.cd_port_en ?
                             isa_dack_n[drq_sel] : 1'b1;
   // Upper address pins unless the CDROM port took them
   assign isa_upper_addr   = straps_ff.cd_port_en ? 4'h0
                                                  : multi_pins_in;
   assign cd_chip_select_n = cs_ff;
   // Master clock gated by the disable bit
   assign synth_mclk    = xtal_clk_gate_in && !master_clock_disable;
   assign synth_mclk_oe = !rst && !reset_drive;
   // Address port selection from the latched straps
   assign config_addr_port = straps_ff.addr_sel_std ? cdpc_pkg::ADDR_PORT_STD :
                             straps_ff.scl_high ? cdpc_pkg::ADDR_PORT_ALT1 :
                             cdpc_pkg::ADDR_PORT_ALT2;
   // Mux pin drives except as volume-down input
   assign mux_pin_out = mux_out_ff;
   assign mux_pin_oe  = (role != cdpc_pkg::MUX_VOL_DOWN);
   assign mux_role    = role;
   // Port pins are inputs only, so they are never driven
   assign va_pins_oe            = 1'b0;
   assign video_audio_serial_in = va_ff[0];
   assign video_audio_lr_clock  = va_ff[1];
   assign video_audio_bit_clock = va_ff[2];
   assign master_volume         = vol_ff;
   assign straps                = straps_ff;

endmodule

// File: testbench/cdpc_pin_config_sva.sv
// Assertions for the CDROM, volume and pin configuration block.
// Assumes inputs hold still while clk_en is low and straps are held.
`timescale 1ns/1ps
module cdpc_pin_config_sva #(
   parameter int ADDR_W = 12              // Decoded address width
) (
   // Clock and reset
   input wire logic                     ref_clk,
   input wire logic                     rst,
   input wire logic                     clk_en,
   // ISA side
   input wire logic                     reset_drive,
   input wire logic [ADDR_W-1:0]        isa_addr,
   input wire logic                     isa_addr_valid,
   input wire logic [3:0]               multi_pins_in,
   input wire logic [3:0]               isa_upper_addr,
   input wire logic [ADDR_W-1:0]        cd_base,
   // Configuration and straps
   input wire logic                     volume_pins_enable,
   input wire logic                     master_clock_disable,
   input wire logic                     mclk_strap_in,
   // Pins and status
   input wire logic                     cd_chip_select_n,
   input wire logic                     mux_pin_oe,
   input wire logic                     mux_pin_in,
   input wire logic                     vol_up_n,
   input wire cdpc_pkg::cdpc_volume_t   master_volume,
   input wire logic                     synth_mclk,
   input wire cdpc_pkg::cdpc_straps_t   straps,
   input wire logic [11:0]              config_addr_port,
   input wire cdpc_pkg::cdpc_mux_role_t mux_role
);
   // ---------------------------------------------------------------
   // One clock domain
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   cs_match_a: assert property (clk_en && straps.cd_port_en &&
      isa_addr_valid && isa_addr == cd_base |=> !cd_chip_select_n)
      else $error("chip select missed a base match");
   cs_idle_a: assert property (!(straps.cd_port_en &&
      isa_addr_valid && isa_addr == cd_base) |=> cd_chip_select_n)
      else $error("chip select low without a match");
   upper_addr_a: assert property (!straps.cd_port_en |->
      isa_upper_addr == multi_pins_in)
      else $error("upper address not passed through");
   vol_role_a: assert property (volume_pins_enable |->
      mux_role == cdpc_pkg::MUX_VOL_DOWN && !mux_pin_oe)
      else $error("mux pin not in volume-down role");
   mclk_gate_a: assert property (master_clock_disable |->
      !synth_mclk)
      else $error("synth clock runs while disabled");
   port_addr_a: assert property (config_addr_port ==
      (straps.addr_sel_std ? 12'h279 : straps.scl_high ? 12'h308 : 12'h388))
      else $error("address port wrong for straps");
   strap_latch_a: assert property ($fell(reset_drive) |->
      ##[1:2] straps.cd_port_en == !mclk_strap_in)
      else $error("cdrom strap not latched");
   vol_hold_a: assert property (!volume_pins_enable |=>
      $stable(master_volume))
      else $error("volume moved with pins disabled");
   vol_up_a: assert property (clk_en && volume_pins_enable &&
      $fell(vol_up_n) && mux_pin_in && master_volume.left != 6'h3f |->
      ##[1:4] $changed(master_volume.left))
      else $error("volume up press had no effect");
endmodule
bind cdpc_pin_config cdpc_pin_config_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// File: testbench/cdpc_cd_drive_model.sv
// Behavioural CDROM drive on the far side of the pin block.
// Assumes the bench drives the go inputs with a random level each cycle.
`timescale 1ns/1ps
module cdpc_cd_drive_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bench commands
   input wire logic irq_go,
   input wire logic dma_go,
   // Pin block side
   input wire logic cd_chip_select_n,
   input wire logic cd_dma_ack_out_n,
   output logic     cd_interrupt_in,
   output logic     cd_dma_request_in
);
   // Interrupt holds until selected, request holds until acknowledged
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cd_interrupt_in <= 1'b0;
         cd_dma_request_in <= 1'b0;
      end else begin
         cd_interrupt_in <= irq_go | (cd_interrupt_in & cd_chip_select_n);
         cd_dma_request_in <= dma_go | (cd_dma_request_in & cd_dma_ack_out_n);
      end
   end
endmodule

// File: testbench/tb_cdpc_pin_config.sv
// Self-checking bench for the CDROM, volume and pin configuration block.
// Assumes the drive model beside it and the bound checker.
`timescale 1ns/1ps
module tb_cdpc_pin_config;
   logic ref_clk, rst, clk_en, reset_drive, isa_addr_valid, cd_irq_polarity;
   logic general_output_one, volume_pins_enable, volume_format_select;
   logic master_clock_disable, video_audio_port_enable, mclk_strap_in;
   logic sdout_strap_in, port_address_strap, scl_strap_in, cd_chip_select_n;
   logic cd_interrupt_in, cd_dma_request_in, cd_dma_ack_out_n, mux_pin_out;
   logic mux_pin_oe, mux_pin_in, vol_up_n, vol_mute_n, xtal_clk_gate_in;
   logic synth_mclk, synth_mclk_oe, va_pins_oe, video_audio_serial_in;
   logic video_audio_lr_clock, video_audio_bit_clock, irq_go, dma_go;
   logic [11:0] isa_addr, cd_base, alt_cd_base, config_addr_port;
   logic [3:0] multi_pins_in, isa_upper_addr, isa_drq, isa_dack_n;
   logic [7:0] isa_irq;
   logic [2:0] irq_sel, va_pins_in;
   logic [1:0] drq_sel;
   logic [31:0] rnd;
   logic [12:0] ev;
   int num_errors, checks;
   cdpc_pkg::cdpc_volume_t master_volume;
   cdpc_pkg::cdpc_straps_t straps;
   cdpc_pkg::cdpc_mux_role_t mux_role;

   cdpc_pin_config dut (.*);
   cdpc_cd_drive_model drive (.ref_clk(ref_clk), .rst(rst), .irq_go(irq_go),
      .dma_go(dma_go), .cd_chip_select_n(cd_chip_select_n),
      .cd_dma_ack_out_n(cd_dma_ack_out_n), .cd_interrupt_in(cd_interrupt_in),
      .cd_dma_request_in(cd_dma_request_in));

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Volume after one press: 0 up, 1 down, 2 mute
   function automatic logic [12:0] vstep(logic [12:0] v, int b, logic f);
      logic [5:0] l;
      l = v[12:7];
      if (b == 0 && l != 6'h3f) l = l + 6'h01;
      if (b == 1 && l != 6'h00) l = l - 6'h01;
      return {l, l, v[0] ^ (b == 2 && f)};
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask
   task automatic stop_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Straps {clock, data-out, port, serial clock}, then random traffic
   task automatic strap(logic [3:0] s);
      reset_drive = 1'b1;
      {mclk_strap_in, sdout_strap_in, port_address_strap, scl_strap_in} = s;
      tick(2);
      chk("mclk_oe", synth_mclk_oe, 1'b0);
      reset_drive = 1'b0;
      tick(2);
      chk("cd_en", straps.cd_port_en, !s[3]);
      chk("alt_en", straps.alt_cs_en, !s[2]);
      chk("port", config_addr_port,
          s[1] ? 12'h279 : s[0] ? 12'h308 : 12'h388);
      chk("role", mux_role, s[2] ? cdpc_pkg::MUX_GEN_OUT :
          cdpc_pkg::MUX_ALT_CS);
      chk("mux_oe", mux_pin_oe, 1'b1);
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         isa_addr = rnd[0] ? cd_base : rnd[1] ? alt_cd_base : rnd[27:16];
         {isa_addr_valid, general_output_one, cd_irq_polarity} = rnd[4:2];
         {irq_sel, drq_sel, isa_dack_n} = rnd[13:5];
         {irq_go, dma_go, multi_pins_in} = {rnd[14], rnd[15], rnd[31:28]};
         tick(1);
         chk("cs", cd_chip_select_n,
             !(!s[3] && isa_addr_valid && isa_addr == cd_base));
         chk("mux", mux_pin_out, s[2] ? general_output_one :
             !(isa_addr_valid && isa_addr == alt_cd_base));
         chk("upper", isa_upper_addr, s[3] ? multi_pins_in : 4'h0);
         chk("irq", isa_irq, s[3] ? 8'h0 :
             {7'h0, cd_interrupt_in ^ cd_irq_polarity} << irq_sel);
         chk("drq", isa_drq, s[3] ? 4'h0 :
             {3'h0, cd_dma_request_in} << drq_sel);
         chk("dack", cd_dma_ack_out_n, s[3] | isa_dack_n[drq_sel]);
      end
      $display("test straps %h done", s);
   endtask
   task automatic press(int b);
      if (b == 0) vol_up_n = 1'b0;
      else if (b == 1) mux_pin_in = 1'b0;
      else vol_mute_n = 1'b0;
      tick(3);
      {vol_up_n, mux_pin_in, vol_mute_n} = 3'b111;
      tick(4);
      if (volume_pins_enable) ev = vstep(ev, b, volume_format_select);
      chk("volume", master_volume, ev);
   endtask

   initial begin
      {rst, clk_en, reset_drive, isa_addr_valid, cd_irq_polarity} = 5'h1e;
      {general_output_one, volume_pins_enable, volume_format_select} = 3'h0;
      {master_clock_disable, video_audio_port_enable, irq_go, dma_go} = 4'h0;
      {mclk_strap_in, sdout_strap_in, port_address_strap, scl_strap_in} = 4'hf;
      {mux_pin_in, vol_up_n, vol_mute_n, xtal_clk_gate_in} = 4'he;
      {isa_addr, cd_base, alt_cd_base} = {12'h000, 12'h1f0, 12'h170};
      {multi_pins_in, isa_dack_n, irq_sel, va_pins_in, drq_sel} = 16'hf000;
      {rnd, ev, num_errors, checks} = {32'hf37dafe1, 13'h0000, 64'h0};
      tick(2);
      rst = 1'b0;
      strap(4'b0011);
      strap(4'b1100);
      strap(4'b0101);
      volume_pins_enable = 1'b1;
      tick(1);
      chk("role", mux_role, cdpc_pkg::MUX_VOL_DOWN);
      for (int i = 0; i < 100; i++) begin
         rnd = lfsr(rnd);
         volume_format_select = rnd[8];
         press(i < 2 ? 1 : i < 68 ? 0 : rnd[1:0] == 2'h3 ? 0 : rnd[1:0]);
      end
      // Frozen clock enable: a press must leave the volume alone
      clk_en = 1'b0;
      if (ev[12:7] == 6'h3f) begin
         mux_pin_in = 1'b0;
      end else begin
         vol_up_n = 1'b0;
      end
      tick(4);
      {vol_up_n, mux_pin_in} = 2'b11;
      tick(4);
      chk("freeze", master_volume, ev);
      clk_en = 1'b1;
      volume_pins_enable = 1'b0;
      for (int b = 0; b < 3; b++) press(b);
      $display("test volume done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         {master_clock_disable, xtal_clk_gate_in} = rnd[1:0];
         {video_audio_port_enable, va_pins_in} = rnd[5:2];
         tick(3);
         chk("mclk", synth_mclk,
             xtal_clk_gate_in & !master_clock_disable);
         chk("mclk_oe", synth_mclk_oe, 1'b1);
         chk("va", {video_audio_bit_clock, video_audio_lr_clock,
                    video_audio_serial_in},
             video_audio_port_enable ? va_pins_in : 3'h0);
         chk("va_oe", va_pins_oe, 1'b0);
      end
      $display("test clock and port done");
      stop_test();
   end

   // Watchdog against a hang
   initial begin
      #500000;
      num_errors++;
      stop_test();
   end
endmodule
